// ---- rtl/lef_defs.svh ----
`ifndef LEF_DEFS_SVH
`define LEF_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define LEF_OFS_IRQ_CTRL 8'h02
`define LEF_OFS_MASK 8'h03
`define LEF_OFS_FLAGS 8'h04
`define LEF_OFS_HOOK 8'h05
`define LEF_OFS_LINE_CFG 8'h06
`define LEF_OFS_STATUS 8'h13

// ************************************************************
// Field positions
// ************************************************************
`define LEF_BIT_RING 7
`define LEF_BIT_RX_OVL 6
`define LEF_BIT_FRAME 5
`define LEF_BIT_BILLING 4
`define LEF_BIT_DROPOUT 3
`define LEF_BIT_LOOP_MAX 2
`define LEF_BIT_POLARITY 0
`define LEF_BIT_GLOBAL_EN 7
`define LEF_BIT_IRQ_POL 6
`define LEF_BIT_EDGE_MODE 2
`define LEF_BIT_RING_NEG 6
`define LEF_BIT_RING_POS 5
`define LEF_BIT_CID_MON 3
`define LEF_BIT_RING_ACT 2
`define LEF_BIT_HOOK 0
`define LEF_BIT_PDL 4
`define LEF_BIT_FULL_WAVE 1
`define LEF_BIT_PIN_EN 0
`define LEF_BIT_ST_OVL 2
`define LEF_BIT_ST_OVC 1
`define LEF_BIT_ST_DROP 0
`define LEF_FLAG_VALID 8'hFD

// ************************************************************
// Reset values and timing
// ************************************************************
`define LEF_RST_BYTE 8'h00
`define LEF_RING_HOLD_S 5
`define LEF_CLK_HZ 25000000
`define LEF_RING_HOLD_CYC (`LEF_RING_HOLD_S * `LEF_CLK_HZ)

`endif

// ---- rtl/lef_pkg.sv ----
package lef_pkg;

  typedef logic [7:0] lef_byte_type;

  typedef enum logic [0:0] {
    LEF_EDGE_START = 1'b0,
    LEF_EDGE_BOTH = 1'b1
  } lef_edge_mode_type;

endpackage : lef_pkg

// ---- rtl/lef_top.sv ----
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "lef_defs.svh"

module lef_top
  import lef_pkg::*;
#(
  parameter bit HAS_LVM = 1'b1,
  parameter int CNT_W = 27,
  parameter logic [CNT_W-1:0] RING_HOLD_CYC =
    CNT_W'(`LEF_RING_HOLD_CYC)
) (
  input wire logic core_clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] addr, // Register address
  input wire logic [7:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [7:0] rd_data, // Read data, cycle after strobe
  input wire logic ring_pos_det, // Positive ring level
  input wire logic ring_neg_det, // Negative ring level
  input wire logic rx_overload_det, // Receive overload event
  input wire logic frame_lock, // Link in frame lock
  input wire logic billing_tone_det, // Billing tone event
  input wire logic supply_dropout_det, // Line supply collapsed
  input wire logic [4:0] loop_current_level, // Loop current level
  input wire logic [7:0] line_voltage_level, // Line voltage level
  input wire logic overcurrent_det, // Overcurrent status level
  input wire logic hook_pin, // Off-hook pin
  output logic irq_pin, // Request pin, programmable level
  output logic off_hook, // Line off-hook
  output logic caller_id_monitor, // On-hook monitor mode
  output logic line_side_powerdown // Line side in low power
);

  // ************************************************************
  // Register bus decode
  // ************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic wr_ctrl = wr_en && hit(addr, `LEF_OFS_IRQ_CTRL);
  wire logic wr_mask = wr_en && hit(addr, `LEF_OFS_MASK);
  wire logic wr_flags = wr_en && hit(addr, `LEF_OFS_FLAGS);
  wire logic wr_hook = wr_en && hit(addr, `LEF_OFS_HOOK);
  wire logic wr_cfg = wr_en && hit(addr, `LEF_OFS_LINE_CFG);

  lef_byte_type flags_q, flags_d, mask_q;
  logic global_en_q, irq_pol_q;
  lef_edge_mode_type edge_mode_q;
  logic cid_mon_q, hook_ctl_q, pdl_q, full_wave_q, pin_en_q;
  logic ovl_status_q, ring_active_q, ring_active_d;
  logic burst_prev_q, lv7_prev_q, lv7_primed_q;
  logic [CNT_W-1:0] hold_cnt_q, hold_cnt_d;
  logic irq_q, off_hook_q, rd_q;
  lef_byte_type rd_data_q;

  // ************************************************************
  // Event detection
  // ************************************************************
  wire logic burst = ring_pos_det || ring_neg_det;
  wire logic ring_start = burst && !burst_prev_q;
  wire logic ring_end = !burst && burst_prev_q;
  wire logic loop_max = &loop_current_level;
  // Monitoring-less variants never see a polarity change
  // No history at first sample after reset, so no false flip
  wire logic pol_flip = HAS_LVM && lv7_primed_q &&
    (line_voltage_level[7] != lv7_prev_q);

  lef_byte_type flag_set;
  assign flag_set[`LEF_BIT_RING] = ring_start ||
    (ring_end && edge_mode_q == LEF_EDGE_BOTH);
  assign flag_set[`LEF_BIT_RX_OVL] = rx_overload_det;
  assign flag_set[`LEF_BIT_FRAME] = !frame_lock;
  assign flag_set[`LEF_BIT_BILLING] = billing_tone_det;
  assign flag_set[`LEF_BIT_DROPOUT] = supply_dropout_det;
  assign flag_set[`LEF_BIT_LOOP_MAX] = loop_max;
  assign flag_set[1] = 1'b0;
  assign flag_set[`LEF_BIT_POLARITY] = pol_flip;

  // Only a written 0 clears; a written 1 is ignored
  wire lef_byte_type flag_clr =
    wr_flags ? (~wr_data & `LEF_FLAG_VALID) : `LEF_RST_BYTE;
  // Set beats clear so no event is lost
  assign flags_d = ((flags_q & ~flag_clr) | flag_set) &
    `LEF_FLAG_VALID;
  wire logic ovl_clr = flag_clr[`LEF_BIT_RX_OVL];

  // ************************************************************
  // Ring active and hook
  // ************************************************************
  wire logic ring_act_set = ring_pos_det ||
    (full_wave_q && ring_neg_det);
  wire logic off_hook_d = hook_ctl_q || (pin_en_q && hook_pin);

  always_comb begin
    hold_cnt_d = hold_cnt_q;
    ring_active_d = ring_active_q;
    if (off_hook_q) begin
      hold_cnt_d = '0;
      ring_active_d = 1'b0;
    end else if (ring_act_set) begin
      hold_cnt_d = RING_HOLD_CYC;
      ring_active_d = 1'b1;
    end else if (hold_cnt_q != '0) begin
      hold_cnt_d = hold_cnt_q - CNT_W'(1);
      if (hold_cnt_q == CNT_W'(1)) begin
        ring_active_d = 1'b0;
      end
    end
  end

  // ************************************************************
  // Request pin
  // ************************************************************
  wire logic irq_act = global_en_q && |(flags_q & mask_q);
  wire logic irq_d = irq_pol_q ? irq_act : !irq_act;

  // ************************************************************
  // Read mux
  // ************************************************************
  lef_byte_type rd_mux;
  always_comb begin
    rd_mux = `LEF_RST_BYTE;
    unique case (addr)
      `LEF_OFS_IRQ_CTRL: begin
        rd_mux[`LEF_BIT_GLOBAL_EN] = global_en_q;
        rd_mux[`LEF_BIT_IRQ_POL] = irq_pol_q;
        rd_mux[`LEF_BIT_EDGE_MODE] = edge_mode_q;
      end
      `LEF_OFS_MASK: rd_mux = mask_q;
      `LEF_OFS_FLAGS: rd_mux = flags_q;
      `LEF_OFS_HOOK: begin
        rd_mux[`LEF_BIT_RING_NEG] = ring_neg_det;
        rd_mux[`LEF_BIT_RING_POS] = ring_pos_det;
        rd_mux[`LEF_BIT_CID_MON] = cid_mon_q;
        rd_mux[`LEF_BIT_RING_ACT] = ring_active_q;
        rd_mux[`LEF_BIT_HOOK] = hook_ctl_q;
      end
      `LEF_OFS_LINE_CFG: begin
        rd_mux[`LEF_BIT_PDL] = pdl_q;
        rd_mux[`LEF_BIT_FULL_WAVE] = full_wave_q;
        rd_mux[`LEF_BIT_PIN_EN] = pin_en_q;
      end
      `LEF_OFS_STATUS: begin
        rd_mux[`LEF_BIT_ST_OVL] = ovl_status_q;
        rd_mux[`LEF_BIT_ST_OVC] = overcurrent_det;
        rd_mux[`LEF_BIT_ST_DROP] = supply_dropout_det;
      end
      default: rd_mux = `LEF_RST_BYTE;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_en_q <= 1'b0;
      irq_pol_q <= 1'b0;
      edge_mode_q <= LEF_EDGE_START;
      mask_q <= `LEF_RST_BYTE;
    end else if (wr_ctrl) begin
      global_en_q <= wr_data[`LEF_BIT_GLOBAL_EN];
      irq_pol_q <= wr_data[`LEF_BIT_IRQ_POL];
      edge_mode_q <= lef_edge_mode_type'(wr_data[`LEF_BIT_EDGE_MODE]);
    end else if (wr_mask) begin
      mask_q <= wr_data & `LEF_FLAG_VALID;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cid_mon_q <= 1'b0;
      hook_ctl_q <= 1'b0;
      pdl_q <= 1'b0;
      full_wave_q <= 1'b0;
      pin_en_q <= 1'b0;
    end else if (wr_hook) begin
      cid_mon_q <= wr_data[`LEF_BIT_CID_MON];
      hook_ctl_q <= wr_data[`LEF_BIT_HOOK];
    end else if (wr_cfg) begin
      pdl_q <= wr_data[`LEF_BIT_PDL];
      full_wave_q <= wr_data[`LEF_BIT_FULL_WAVE];
      pin_en_q <= wr_data[`LEF_BIT_PIN_EN];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `LEF_RST_BYTE;
      ovl_status_q <= 1'b0;
      burst_prev_q <= 1'b0;
      lv7_prev_q <= 1'b0;
      lv7_primed_q <= 1'b0;
      hold_cnt_q <= '0;
      ring_active_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      ovl_status_q <= rx_overload_det || (ovl_status_q && !ovl_clr);
      burst_prev_q <= burst;
      lv7_prev_q <= line_voltage_level[7];
      lv7_primed_q <= 1'b1;
      hold_cnt_q <= hold_cnt_d;
      ring_active_q <= ring_active_d;
    end
  end

  // Idle request pin is high while polarity resets to active low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b1;
      off_hook_q <= 1'b0;
      rd_q <= 1'b0;
      rd_data_q <= `LEF_RST_BYTE;
    end else begin
      irq_q <= irq_d;
      off_hook_q <= off_hook_d;
      rd_q <= rd_en;
      rd_data_q <= rd_en ? rd_mux : `LEF_RST_BYTE;
    end
  end

  assign rd_data = rd_data_q;
  assign irq_pin = irq_q;
  assign off_hook = off_hook_q;
  assign caller_id_monitor = cid_mon_q;
  assign line_side_powerdown = pdl_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ring_end_both;
    ring_end && edge_mode_q == LEF_EDGE_BOTH;
  endsequence

  sequence s_ring_hold_expire;
    ring_active_q && hold_cnt_q == CNT_W'(1) && !ring_act_set && !off_hook_q;
  endsequence

  AST_RING_START: assert property (ring_start |=> flags_q[7])
    else $error("ring flag not set at burst start");
  AST_RING_END_BOTH: assert property (s_ring_end_both |=> flags_q[7])
    else $error("ring flag not set at burst end");
  AST_RING_END_START: assert property (
    ring_end && edge_mode_q == LEF_EDGE_START && !flags_q[7]
    |=> !flags_q[7])
    else $error("ring flag set at burst end in start mode");
  AST_OVL_CLEAR: assert property (
    ovl_status_q && ovl_clr && !rx_overload_det |=> !ovl_status_q)
    else $error("overload status not cleared with flag");
  AST_FRAME_LOSS: assert property (!frame_lock |=> flags_q[5])
    else $error("frame loss flag not set");
  AST_BILLING_STICKY: assert property (
    flags_q[4] && !flag_clr[4] |=> flags_q[4])
    else $error("billing flag dropped without clear");
  AST_DROP_SET_WINS: assert property (
    supply_dropout_det && wr_flags |=> flags_q[3])
    else $error("dropout event lost to clear");
  AST_LOOP_MAX: assert property (
    loop_max |=> flags_q[2])
    else $error("loop max flag not set");
  AST_POL_FLIP: assert property (
    HAS_LVM && $changed(line_voltage_level[7]) && $past(rst_n)
    |=> flags_q[0])
    else $error("polarity flag not set on toggle");
  AST_WRITE_ZERO: assert property (
    wr_flags && !wr_data[6] && flag_set == '0 |=> !flags_q[6])
    else $error("flag not cleared by writing zero");
  AST_IRQ_PIN: assert property (
    ##1 irq_pin == ($past(irq_pol_q) ?
      ($past(global_en_q) && |($past(flags_q) & $past(mask_q))) :
      !($past(global_en_q) && |($past(flags_q) & $past(mask_q)))))
    else $error("request pin level wrong");
  AST_RING_LIVE: assert property (
    rd_en && addr == `LEF_OFS_HOOK
    |=> rd_data[6:5] == {$past(ring_neg_det), $past(ring_pos_det)})
    else $error("live ring bits wrong");
  AST_CID_MON: assert property (
    wr_hook |=> caller_id_monitor == $past(wr_data[3]))
    else $error("monitor mode not written");
  AST_RING_OFFHOOK: assert property (off_hook_q |=> !ring_active_q)
    else $error("ring active kept while off-hook");
  AST_RING_EXPIRE: assert property (
    s_ring_hold_expire |=> !ring_active_q)
    else $error("ring active not cleared at expiry");
  AST_HALF_WAVE: assert property (
    !full_wave_q && !ring_pos_det && !ring_active_q |=> !ring_active_q)
    else $error("negative ring set ring active in half wave");
  AST_OFF_HOOK: assert property (
    hook_ctl_q || (pin_en_q && hook_pin) |=> off_hook)
    else $error("line not taken off-hook");
  AST_WRITE_ONE: assert property (
    wr_flags && flags_q[5] && wr_data[5] |=> flags_q[5])
    else $error("writing one changed a flag");
  AST_RD_ONCE: assert property (!rd_q |-> rd_data == '0)
    else $error("read data outside answer cycle");

endmodule : lef_top

// ---- verification/lef_line_model.sv ----
`timescale 1ns/100ps

// ************************************************************
// Line-side detector model
// ************************************************************
// Levels only move through set(), called just after a clock edge
module lef_line_model (
  output logic ring_pos_det, // Positive ring level
  output logic ring_neg_det, // Negative ring level
  output logic rx_overload_det, // Overload event
  output logic frame_lock, // Link locked
  output logic billing_tone_det, // Billing tone
  output logic supply_dropout_det, // Supply collapsed
  output logic [4:0] loop_current_level, // Loop level
  output logic [7:0] line_voltage_level, // Line voltage
  output logic overcurrent_det // Overcurrent level
);
  initial begin
    ring_pos_det = 1'b0;
    ring_neg_det = 1'b0;
    rx_overload_det = 1'b0;
    frame_lock = 1'b1;
    billing_tone_det = 1'b0;
    supply_dropout_det = 1'b0;
    loop_current_level = 5'h0_3;
    line_voltage_level = 8'h0_0;
    overcurrent_det = 1'b0;
  end

  // Index 6 flips the voltage sign bit on every call, either way
  task automatic set(input int k, input logic v);
    case (k)
      0: ring_pos_det <= v;
      1: rx_overload_det <= v;
      2: frame_lock <= ~v;
      3: billing_tone_det <= v;
      4: supply_dropout_det <= v;
      5: loop_current_level <= v ? 5'h1_F : 5'h0_3;
      6: line_voltage_level[7] <= ~line_voltage_level[7];
      7: ring_neg_det <= v;
      default: overcurrent_det <= v;
    endcase
  endtask : set
endmodule : lef_line_model

// ---- verification/test_line_event_flags_and_hook_control.sv ----
`timescale 1ns/100ps

module test_line_event_flags_and_hook_control;
  import lef_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h0_0;
  logic [7:0] wr_data = 8'h0_0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hook_pin = 1'b0;
  logic [7:0] rd_data;
  logic rpos, rneg, ovl, lock, bill, drop, ovc;
  logic [4:0] loop_lvl;
  logic [7:0] volt;
  logic irq_pin, off_hook, caller_id_monitor, line_side_powerdown;
  int bad_count = 0;
  int n_checks = 0;
  lef_byte_type bits [7] = '{8'h8_0, 8'h4_0, 8'h2_0, 8'h1_0,
                              8'h0_8, 8'h0_4, 8'h0_1};

  always #20 core_clk = ~core_clk;

  lef_line_model u_line (.ring_pos_det(rpos), .ring_neg_det(rneg),
    .rx_overload_det(ovl), .frame_lock(lock), .billing_tone_det(bill),
    .supply_dropout_det(drop), .loop_current_level(loop_lvl),
    .line_voltage_level(volt), .overcurrent_det(ovc));

  lef_top #(.RING_HOLD_CYC(27'd20)) u_dut (.core_clk(core_clk),
    .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .ring_pos_det(rpos),
    .ring_neg_det(rneg), .rx_overload_det(ovl), .frame_lock(lock),
    .billing_tone_det(bill), .supply_dropout_det(drop),
    .loop_current_level(loop_lvl), .line_voltage_level(volt),
    .overcurrent_det(ovc), .hook_pin(hook_pin), .irq_pin(irq_pin),
    .off_hook(off_hook), .caller_id_monitor(caller_id_monitor),
    .line_side_powerdown(line_side_powerdown));

  // ************************************************************
  // Bus tasks and checks
  // ************************************************************
  task automatic chk(input lef_byte_type g, input lef_byte_type e);
    n_checks++;
    if (g !== e) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input lef_byte_type a, input lef_byte_type d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input lef_byte_type a, input lef_byte_type e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask : rd

  task automatic evt(input int k);
    @(posedge core_clk);
    u_line.set(k, 1'b1);
    @(posedge core_clk);
    u_line.set(k, 1'b0);
  endtask : evt

  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    chk1(irq_pin, 1'b1);
    foreach (bits[i]) rd(i < 5 ? 8'(8'h0_2 + i) : 8'h1_3, 8'h0_0);
    rd(8'h0_7, 8'h0_0);
    wr(8'h0_7, 8'hF_F);
    rd(8'h0_7, 8'h0_0);
    foreach (bits[i]) begin
      evt(i);
      rd(8'h0_4, bits[i]);
      rd(8'h1_3, i == 1 ? 8'h0_4 : 8'h0_0);
      wr(8'h0_4, 8'hF_F);
      rd(8'h0_4, bits[i]);
      wr(8'h0_4, ~bits[i]);
      rd(8'h0_4, 8'h0_0);
      rd(8'h1_3, 8'h0_0);
    end
    u_line.set(8, 1'b1);
    u_line.set(4, 1'b1);
    rd(8'h1_3, 8'h0_3);
    wr(8'h0_4, 8'h0_0);
    rd(8'h0_4, 8'h0_8);
    u_line.set(8, 1'b0);
    u_line.set(4, 1'b0);
    u_line.set(2, 1'b1);
    cyc(2);
    wr(8'h0_4, 8'h0_0);
    rd(8'h0_4, 8'h2_0);
    u_line.set(2, 1'b0);
    wr(8'h0_4, 8'h0_0);
    rd(8'h0_4, 8'h0_0);
    // Request pin across mask, enable and polarity
    wr(8'h0_3, 8'h8_0);
    wr(8'h0_2, 8'h8_0);
    evt(0);
    cyc(3);
    chk1(irq_pin, 1'b0);
    wr(8'h0_2, 8'hC_0);
    cyc(2);
    chk1(irq_pin, 1'b1);
    wr(8'h0_4, 8'h7_F);
    cyc(2);
    chk1(irq_pin, 1'b0);
    evt(3);
    cyc(3);
    chk1(irq_pin, 1'b0);
    wr(8'h0_3, 8'h1_0);
    wr(8'h0_2, 8'h4_0);
    cyc(2);
    chk1(irq_pin, 1'b0);
    wr(8'h0_2, 8'hC_0);
    cyc(2);
    chk1(irq_pin, 1'b1);
    wr(8'h0_3, 8'h0_0);
    // Burst end flag only in both-edge mode
    for (int m = 0; m < 2; m++) begin
      wr(8'h0_4, 8'h0_0);
      wr(8'h0_2, m == 1 ? 8'h0_4 : 8'h0_0);
      u_line.set(0, 1'b1);
      cyc(2);
      wr(8'h0_4, 8'h0_0);
      u_line.set(0, 1'b0);
      cyc(3);
      rd(8'h0_4, m == 1 ? 8'h8_0 : 8'h0_0);
    end
    cyc(30);
    u_line.set(7, 1'b1);
    rd(8'h0_5, 8'h4_0);
    u_line.set(7, 1'b0);
    u_line.set(0, 1'b1);
    rd(8'h0_5, 8'h2_4);
    u_line.set(0, 1'b0);
    cyc(30);
    wr(8'h0_6, 8'h0_2);
    u_line.set(7, 1'b1);
    rd(8'h0_5, 8'h4_4);
    u_line.set(7, 1'b0);
    cyc(8);
    rd(8'h0_5, 8'h0_4);
    cyc(20);
    rd(8'h0_5, 8'h0_0);
    evt(0);
    wr(8'h0_5, 8'h0_9);
    cyc(3);
    chk({6'h00, off_hook, caller_id_monitor}, 8'h0_3);
    rd(8'h0_5, 8'h0_9);
    wr(8'h0_5, 8'h0_0);
    wr(8'h0_6, 8'h0_1);
    hook_pin <= 1'b1;
    cyc(3);
    chk1(off_hook, 1'b1);
    wr(8'h0_6, 8'h0_0);
    cyc(3);
    chk1(off_hook, 1'b0);
    hook_pin <= 1'b0;
    wr(8'h0_6, 8'h1_0);
    cyc(2);
    chk1(line_side_powerdown, 1'b1);
    wr(8'h0_6, 8'h0_0);
    wr(8'h0_4, 8'h7_7);
    rd(8'h0_4, 8'h0_0);
    end_sim();
  end
endmodule : test_line_event_flags_and_hook_control
